// [quad_timer_pkg.sv]
// Shared constants and types for the four-timer counting unit.
package quad_timer_pkg;

    // Counter geometry.
    localparam int NUM_TIMERS = 4;
    localparam int NUM_PAIRS  = 2;
    localparam int CNT_W      = 8;

    // Counter values of note.
    localparam logic [7:0] CNT_ZERO  = 8'h00;
    localparam logic [7:0] CNT_MAX   = 8'hFF;
    localparam logic [7:0] CNT_RESET = 8'h00;

    // Timer clock selection codes.
    localparam logic [1:0] CLK_LOW     = 2'h0;
    localparam logic [1:0] CLK_HIGH    = 2'h1;
    localparam logic [1:0] CLK_EXT     = 2'h2;
    localparam logic [1:0] CLK_CASCADE = 2'h3;

    // Positions of the pin inputs in the synchroniser vector.
    localparam int NUM_PINS   = 8;
    localparam int PIN_LOW    = 0;
    localparam int PIN_HIGH   = 1;
    localparam int PIN_EXT02  = 2;
    localparam int PIN_EXT13  = 3;
    localparam int PIN_TB64   = 4;
    localparam int PIN_WINDOW = 5;
    localparam int PIN_CAP0   = 6;
    localparam int PIN_CAP1   = 7;

    // Interrupt vector addresses, timer 3 down to timer 0.
    localparam logic [3:0][15:0] VECTOR_ADDR = {16'h0026, 16'h0024, 16'h0022, 16'h0020};
    localparam logic [15:0]      VEC_NONE    = 16'h0000;

    // Frequency measurement sequencer states.
    typedef enum logic [1:0] {FM_IDLE, FM_WAIT, FM_COUNT} freq_state_e;

endpackage

// [timer_slice.sv]
// One 8-bit timer: counter, data register, reload and capture.
`timescale 1ns/1ps
module timer_slice
    import quad_timer_pkg::*;
#(
    parameter int WIDTH = CNT_W
)
(
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             tick,
    input  wire logic             reloadOk,
    input  wire logic             captureMode,
    input  wire logic             captureNow,
    input  wire logic             cntWrite,
    input  wire logic             dataWrite,
    input  wire logic [WIDTH-1:0] wrData,
    output logic      [WIDTH-1:0] count,
    output logic      [WIDTH-1:0] data,
    output logic                  overflow
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;

    // Overflow is the tick that leaves the all-ones value.
    assign overflow = tick && (count_reg == {WIDTH{1'b1}});
    assign count    = count_reg;
    assign data     = data_reg;

    // A software write to the counter wins over counting, so that
    // the reload value and the count always agree after a write.
    always_comb
    begin
        count_next = count_reg;
        data_next  = data_reg;
        if (cntWrite)
        begin
            count_next = wrData;
            data_next  = wrData;
        end
        else
        begin
            if (tick)
            begin
                if (!overflow)
                    count_next = count_reg + 1'b1;
                else if (captureMode || !reloadOk)
                    count_next = '0;
                else
                    count_next = data_reg;
            end
            if (dataWrite)
                data_next = wrData;
            else if (captureNow)
                data_next = count_reg;
        end
    end

    // State registers.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            count_reg <= '0;
            data_reg  <= '0;
        end
        else
        begin
            count_reg <= count_next;
            data_reg  <= data_next;
        end
    end

endmodule

// [quad_timer_modes_unit.sv]
// Four 8-bit timers with pairing, reload, capture and frequency measurement.
`timescale 1ns/1ps
module quad_timer_modes_unit
    import quad_timer_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  lowSpeedClk,
    input  wire logic                  highSpeedClk,
    input  wire logic                  extClk02,
    input  wire logic                  extClk13,
    input  wire logic                  timeBase64Hz,
    input  wire logic                  measureWindowPulse,
    input  wire logic                  capturePin0,
    input  wire logic                  capturePin1,
    input  wire logic [3:0]            runBit,
    input  wire logic [1:0]            captureEnable,
    input  wire logic [3:0][1:0]       clockSelect,
    input  wire logic [1:0]            freqWrite,
    input  wire logic [1:0]            freqWriteData,
    input  wire logic [7:0]            writeData,
    input  wire logic [3:0]            counterWrite,
    input  wire logic [3:0]            dataWrite,
    input  wire logic [1:0]            statusRead,
    input  wire logic [3:0]            enableRegTwo,
    input  wire logic                  masterIrqEnable,
    input  wire logic [3:0]            requestClear,
    output logic      [3:0][7:0]       counterValue,
    output logic      [3:0][7:0]       dataValue,
    output logic      [3:0]            overflowFlag,
    output logic                       portBPin0,
    output logic                       portBPin1,
    output logic      [1:0]            captureFlag,
    output logic      [1:0]            freqMeasureBit,
    output logic      [3:0]            requestRegTwo,
    output logic                       cpuIrq,
    output logic      [15:0]           irqVector
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic [NUM_PINS-1:0] pinRaw;
    logic [NUM_PINS-1:0] sync1_reg;
    logic [NUM_PINS-1:0] sync2_reg;
    logic [NUM_PINS-1:0] sync3_reg;
    logic [NUM_PINS-1:0] pinLevel_reg;
    logic [NUM_PINS-1:0] pinLevel_next;
    logic [NUM_PINS-1:0] pinFall;
    logic [NUM_PINS-1:0] pinChange;

    assign pinRaw = {capturePin1, capturePin0, measureWindowPulse, timeBase64Hz,
                     extClk13, extClk02, highSpeedClk, lowSpeedClk};

    // A level is accepted only once the second and third stages agree,
    // which filters a single-cycle glitch on a slow pin.
    always_comb
    begin
        pinLevel_next = pinLevel_reg;
        for (int k = 0; k < NUM_PINS; k++)
        begin
            if (sync2_reg[k] == sync3_reg[k])
                pinLevel_next[k] = sync3_reg[k];
        end
    end

    assign pinFall   = pinLevel_reg & ~pinLevel_next;
    assign pinChange = pinLevel_reg ^ pinLevel_next;

    // Synchroniser stages and accepted levels.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            sync3_reg    <= '0;
            pinLevel_reg <= '0;
        end
        else
        begin
            sync1_reg    <= pinRaw;
            sync2_reg    <= sync1_reg;
            sync3_reg    <= sync2_reg;
            pinLevel_reg <= pinLevel_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer clock selection and run arming.

    logic [3:0]  selFall;
    logic [3:0]  active_reg;
    logic [3:0]  active_next;
    logic [3:0]  tick;
    logic [3:0]  ovf;
    logic [3:0]  reloadOk;
    logic [3:0]  captureMode;
    logic [3:0]  captureNow;
    logic [1:0]  paired;
    freq_state_e fmState_reg [NUM_PAIRS];
    freq_state_e fmState_next [NUM_PAIRS];

    // Falling edges of the selected clock; the cascade code is resolved
    // per pair below, so a lower timer treats it as the fast clock.
    always_comb
    begin
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
            case (clockSelect[i])
                CLK_LOW:  selFall[i] = pinFall[PIN_LOW];
                CLK_HIGH: selFall[i] = pinFall[PIN_HIGH];
                CLK_EXT:  selFall[i] = (i % 2 == 0) ? pinFall[PIN_EXT02]
                                                     : pinFall[PIN_EXT13];
                default:  selFall[i] = pinFall[PIN_HIGH];
            endcase
        end
    end

    // The first falling edge after run arms the timer without counting and
    // the first edge after run clears disarms it, also without counting.
    always_comb
    begin
        active_next = active_reg;
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
            if (selFall[i])
                active_next[i] = runBit[i];
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            active_reg <= '0;
        else
            active_reg <= active_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pairing, ticks and counters.

    for (genvar p = 0; p < NUM_PAIRS; p++)
    begin : g_pair
        localparam int LO = 2 * p;
        localparam int HI = 2 * p + 1;

        assign paired[p] = (clockSelect[HI] == CLK_CASCADE);

        // Measurement counts only inside the window and not while waiting for it; when idle, run rules.
        assign tick[LO] = (fmState_reg[p] == FM_COUNT) ? selFall[LO]
                        : (fmState_reg[p] == FM_IDLE) && selFall[LO]
                          && active_reg[LO] && runBit[LO];

        // The upper run bit is ignored when cascaded.
        assign tick[HI] = paired[p] ? ovf[LO]
                        : selFall[HI] && active_reg[HI] && runBit[HI];

        // A paired lower half reloads only on the full 16-bit overflow.
        assign reloadOk[LO] = !paired[p] || ovf[HI];
        assign reloadOk[HI] = 1'b1;
    end

    logic [1:0] capFlag_reg;
    logic [1:0] capFlag_next;
    logic       run0;
    logic       run1;
    logic       trig1;
    logic [1:0] freqMeasureBit_reg;
    logic [1:0] freqMeasureBit_next;

    // Capture exists on timers 0 and 1 only.
    assign captureMode[0] = captureEnable[0] && !freqMeasureBit_reg[0];
    assign captureMode[1] = captureEnable[1] || (paired[0] && captureMode[0]);
    assign captureMode[3:2] = 2'b00;

    // Triggers come from the synchronised pins, a few system clocks after
    // the change and so well inside one timer clock period.
    assign run0  = active_reg[0] && runBit[0];
    assign run1  = paired[0] ? run0 : (active_reg[1] && runBit[1]);
    assign trig1 = paired[0] ? pinChange[PIN_CAP0] : pinChange[PIN_CAP1];
    assign captureNow[0] = captureMode[0] && pinChange[PIN_CAP0] && run0
                           && !capFlag_reg[0];
    assign captureNow[1] = captureMode[1] && trig1 && run1
                           && !capFlag_reg[1];
    assign captureNow[3:2] = 2'b00;

    for (genvar t = 0; t < NUM_TIMERS; t++)
    begin : g_timer
        timer_slice #(.WIDTH(CNT_W)) u_slice (
            .clock       (clock),
            .srst        (srst),
            .tick        (tick[t]),
            .reloadOk    (reloadOk[t]),
            .captureMode (captureMode[t]),
            .captureNow  (captureNow[t]),
            .cntWrite    (counterWrite[t]),
            .dataWrite   (dataWrite[t]),
            .wrData      (writeData),
            .count       (counterValue[t]),
            .data        (dataValue[t]),
            .overflow    (ovf[t])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture flags and frequency measurement sequencer.

    // A capture in the same cycle as the status read survives the read.
    assign capFlag_next = captureNow[1:0] | (capFlag_reg & ~statusRead);

    // The window clears the measure bit; a software write the same cycle wins.
    always_comb
    begin
        fmState_next        = fmState_reg;
        freqMeasureBit_next = freqMeasureBit_reg;
        for (int p = 0; p < NUM_PAIRS; p++)
        begin
            case (fmState_reg[p])
                FM_IDLE:
                    if (freqMeasureBit_reg[p])
                        fmState_next[p] = FM_WAIT;
                FM_WAIT:
                    if (!freqMeasureBit_reg[p])
                        fmState_next[p] = FM_IDLE;
                    else if (pinFall[PIN_TB64])
                        fmState_next[p] = FM_COUNT;
                FM_COUNT:
                    if (pinLevel_reg[PIN_WINDOW])
                    begin
                        fmState_next[p]        = FM_IDLE;
                        freqMeasureBit_next[p] = 1'b0;
                    end
                    else if (!freqMeasureBit_reg[p])
                        fmState_next[p] = FM_IDLE;
                default:
                    fmState_next[p] = FM_IDLE;
            endcase
            if (freqWrite[p])
                freqMeasureBit_next[p] = freqWriteData[p];
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            capFlag_reg        <= '0;
            freqMeasureBit_reg <= '0;
            fmState_reg        <= '{default: FM_IDLE};
        end
        else
        begin
            capFlag_reg        <= capFlag_next;
            freqMeasureBit_reg <= freqMeasureBit_next;
            fmState_reg        <= fmState_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flags and interrupt requests.

    logic [3:0]  toggle_reg;
    logic [3:0]  toggle_next;
    logic [3:0]  request_reg;
    logic [3:0]  request_next;
    logic [3:0]  pending;
    logic        irq_reg;
    logic        irq_next;
    logic [15:0] vector_reg;
    logic [15:0] vector_next;

    assign toggle_next  = toggle_reg ^ ovf;
    assign request_next = ovf | (request_reg & ~requestClear);
    assign pending      = request_reg & enableRegTwo;

    // The lowest timer number has the highest priority for the vector.
    always_comb
    begin
        irq_next    = masterIrqEnable && (|pending);
        vector_next = VEC_NONE;
        for (int i = NUM_TIMERS - 1; i >= 0; i--)
        begin
            if (pending[i])
                vector_next = VECTOR_ADDR[i];
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            toggle_reg  <= '0;
            request_reg <= '0;
            irq_reg     <= 1'b0;
            vector_reg  <= VEC_NONE;
        end
        else
        begin
            toggle_reg  <= toggle_next;
            request_reg <= request_next;
            irq_reg     <= irq_next;
            vector_reg  <= vector_next;
        end
    end

    // Outputs, all taken from flip-flops.
    assign overflowFlag   = toggle_reg;
    assign portBPin0      = toggle_reg[0];
    assign portBPin1      = toggle_reg[1];
    assign captureFlag    = capFlag_reg;
    assign freqMeasureBit = freqMeasureBit_reg;
    assign requestRegTwo  = request_reg;
    assign cpuIrq         = irq_reg;
    assign irqVector      = vector_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    chk_irq_request: assert property (ovf[2] |=> requestRegTwo[2])
        else $error("overflow did not raise request");
    chk_ovf_toggle: assert property (ovf[0] |=> overflowFlag[0] != $past(overflowFlag[0]))
        else $error("overflow flag did not toggle");
    chk_irq_gate: assert property (
        cpuIrq |-> $past(masterIrqEnable) && $past(|(requestRegTwo & enableRegTwo)))
        else $error("interrupt without both enables");
    chk_reload_copy: assert property (
        ovf[2] && !paired[1] && !counterWrite[2] |=> counterValue[2] == $past(dataValue[2]))
        else $error("reload value not loaded");
    chk_capture_wrap: assert property (
        ovf[0] && captureMode[0] && !counterWrite[0] |=> counterValue[0] == CNT_ZERO)
        else $error("capture mode overflow did not clear");
    chk_capture_load: assert property (
        captureNow[0] && !dataWrite[0] && !counterWrite[0]
        |=> captureFlag[0] && dataValue[0] == $past(counterValue[0]))
        else $error("capture did not load data");
    chk_capture_hold: assert property (
        captureFlag[0] && !statusRead[0]
        |=> captureFlag[0] && $stable(dataValue[0]) || $past(dataWrite[0] || counterWrite[0]))
        else $error("capture flag or data changed while held");
    chk_arm_start: assert property (
        !active_reg[0] && fmState_reg[0] == FM_IDLE && !counterWrite[0]
        |=> $stable(counterValue[0]))
        else $error("counted before arming edge");
    chk_run_halt: assert property (
        !runBit[2] && !paired[1] && fmState_reg[1] == FM_IDLE && !counterWrite[2]
        |=> $stable(counterValue[2]))
        else $error("counter moved while stopped");
    chk_pair_tick: assert property (paired[0] |-> tick[1] == ovf[0])
        else $error("upper timer not clocked by lower overflow");
    chk_window_stop: assert property (
        fmState_reg[0] == FM_COUNT && pinLevel_reg[PIN_WINDOW] && !freqWrite[0]
        |=> !freqMeasureBit[0] ##1 fmState_reg[0] != FM_COUNT)
        else $error("window did not end measurement");
    chk_write_mirror: assert property (
        counterWrite[3] |=> dataValue[3] == $past(writeData))
        else $error("counter write not mirrored");

endmodule

// [pin_side_model.sv]
// Far-side pin model: free-running timer clock sources and the capture inputs.
`timescale 1ns/1ps
module pin_side_model
(
    output logic lowSpeedClk,
    output logic highSpeedClk,
    output logic timeBase64Hz,
    output logic measureWindowPulse,
    output logic capturePin0,
    output logic capturePin1
);
    ////////////////////////////////////////////////////////////////////////////
    // The slow clock is scaled down to 16 system cycles so the run stays short.
    initial
    begin
        lowSpeedClk  = 1'h1;
        highSpeedClk = 1'h1;
        timeBase64Hz = 1'h1;
        measureWindowPulse = 1'h0;
        capturePin0  = 1'h0;
        capturePin1  = 1'h0;
    end
    always #200 lowSpeedClk = ~lowSpeedClk;
    // The fast clock runs from time zero, long settled before any measurement.
    always #75 highSpeedClk = ~highSpeedClk;

    ////////////////////////////////////////////////////////////////////////////
    // A level change is held for many system cycles so the synchroniser sees it.
    task automatic toggleCapture0();
        capturePin0 = ~capturePin0;
    endtask
    // The time base falls once and the window then stays high, as one run makes
    // only one measurement.
    task automatic openWindow();
        timeBase64Hz = 1'h0;
    endtask
    task automatic closeWindow();
        measureWindowPulse = 1'h1;
    endtask
endmodule

// [testbench.sv]
// Self-checking bench for the four-timer unit: reload, interrupts, capture, stop.
`timescale 1ns/1ps
module testbench;
    import quad_timer_pkg::*;
    logic            clock, srst, lowSpeedClk, highSpeedClk, capturePin0, capturePin1;
    logic            timeBase64Hz, measureWindowPulse;
    logic            masterIrqEnable, cpuIrq, portBPin0, portBPin1;
    logic [3:0]      runBit, counterWrite, dataWrite, enableRegTwo, requestClear;
    logic [3:0]      overflowFlag, requestRegTwo;
    logic [1:0]      captureEnable, freqWrite, freqWriteData, statusRead;
    logic [1:0]      captureFlag, freqMeasureBit;
    logic [3:0][1:0] clockSelect;
    logic [7:0]      writeData, held;
    logic [3:0][7:0] counterValue, dataValue;
    logic [15:0]     irqVector;
    int              nFail, cmpCount, i;

    pin_side_model i_pin_side_model (.lowSpeedClk(lowSpeedClk), .highSpeedClk(highSpeedClk),
        .timeBase64Hz(timeBase64Hz), .measureWindowPulse(measureWindowPulse),
        .capturePin0(capturePin0), .capturePin1(capturePin1));
    quad_timer_modes_unit i_quad_timer_modes_unit (.clock(clock), .srst(srst),
        .lowSpeedClk(lowSpeedClk), .highSpeedClk(highSpeedClk), .extClk02(1'h0),
        .extClk13(1'h0), .timeBase64Hz(timeBase64Hz), .measureWindowPulse(measureWindowPulse),
        .capturePin0(capturePin0), .capturePin1(capturePin1), .runBit(runBit),
        .captureEnable(captureEnable), .clockSelect(clockSelect), .freqWrite(freqWrite),
        .freqWriteData(freqWriteData), .writeData(writeData), .counterWrite(counterWrite),
        .dataWrite(dataWrite), .statusRead(statusRead), .enableRegTwo(enableRegTwo),
        .masterIrqEnable(masterIrqEnable), .requestClear(requestClear),
        .counterValue(counterValue), .dataValue(dataValue), .overflowFlag(overflowFlag),
        .portBPin0(portBPin0), .portBPin1(portBPin1), .captureFlag(captureFlag),
        .freqMeasureBit(freqMeasureBit), .requestRegTwo(requestRegTwo), .cpuIrq(cpuIrq),
        .irqVector(irqVector));

    ////////////////////////////////////////////////////////////////////////////
    // Inputs move 2 ns after the rising edge so the design never races the bench.
    initial
    begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmpCount++;
        if (got !== exp)
        begin
            nFail++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic stopTest();
        $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // A bounded wait that ran out is a hang, so the run is closed at once.
    task automatic timedOut(input string what);
        nFail++;
        $display("MISMATCH at %0t: timeout waiting for %s", $time, what);
        stopTest();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Counter write mirrors into data; a data write leaves the counter alone.
    task automatic writeRegs();
        writeData = 8'hFD; counterWrite = 4'h9; step(1); counterWrite = 4'h0;
        writeData = 8'h40; dataWrite = 4'h1; step(1); dataWrite = 4'h0; step(1);
        check(counterValue[0], 8'hFD, "counter after write");
        check(dataValue[0], 8'h40, "data after data write");
        check(dataValue[3], 8'hFD, "mirrored data");
    endtask
    // Overflow reloads, toggles the flag and pin, and raises a maskable request.
    task automatic reloadAndIrq();
        captureEnable = 2'h0;
        enableRegTwo = 4'h1; masterIrqEnable = 1'h1; clockSelect[2] = CLK_HIGH;
        runBit = 4'h5; step(16);
        check(counterValue[0], 8'hFD, "no count on arming edge");
        for (i = 0; i < 2000 && overflowFlag[0] !== 1'h1; i++) step(1);
        if (i == 2000) timedOut("overflow");
        check(counterValue[0], 8'h40, "reloaded counter");
        check(portBPin0, 1'h1, "overflow pin");
        check(requestRegTwo[0], 1'h1, "request flag");
        step(1);
        check(cpuIrq, 1'h1, "cpu request");
        check(irqVector, 16'h0020, "vector");
        masterIrqEnable = 1'h0; step(2);
        check(cpuIrq, 1'h0, "masked request");
        requestClear = 4'h1; step(1); requestClear = 4'h0; step(1);
        check(requestRegTwo[0], 1'h0, "cleared request");
        for (i = 0; i < 4000 && overflowFlag[0] !== 1'h0; i++) step(1);
        if (i == 4000) timedOut("second overflow");
        check(counterValue[0], 8'h40, "second reload");
        check(requestRegTwo[2], 1'h1, "fast timer request");
    endtask
    // Clearing the run bit freezes the counter within one slow clock period.
    task automatic stopCount();
        runBit = 4'h0; step(40); held = counterValue[0]; step(100);
        check(counterValue[0], held, "stopped counter");
    endtask
    // A capture loads data and sets the flag; a second change is ignored until read.
    task automatic captureRun();
        writeData = 8'hFE; counterWrite = 4'h1; step(1); counterWrite = 4'h0;
        captureEnable = 2'h1; runBit = 4'h1; step(200);
        check(counterValue[0] < 8'h20, 1'h1, "capture mode restart");
        i_pin_side_model.toggleCapture0();
        for (i = 0; i < 16 && captureFlag[0] !== 1'h1; i++) step(1);
        if (i == 16) timedOut("capture");
        held = dataValue[0];
        check(held === counterValue[0] || held + 8'h01 === counterValue[0], 1'h1,
              "captured count");
        i_pin_side_model.toggleCapture0(); step(60);
        check(dataValue[0], held, "capture while flag set");
        statusRead = 2'h1; step(1); statusRead = 2'h0; step(1);
        check(captureFlag[0], 1'h0, "flag after status read");
        runBit = 4'h0;
    endtask
    // A paired measurement counts about twenty fast-clock falls; F0 in the lower
    // half forces one 16-bit overflow, so the reload of both halves is seen too.
    task automatic freqMeasure();
        captureEnable = 2'h0; runBit = 4'h0;
        clockSelect[0] = CLK_HIGH; clockSelect[1] = CLK_CASCADE;
        writeData = 8'hF0; counterWrite = 4'h1; step(1);
        writeData = 8'hFF; counterWrite = 4'h2; step(1); counterWrite = 4'h0;
        freqWrite = 2'h1; freqWriteData = 2'h1; step(1); freqWrite = 2'h0;
        check(freqMeasureBit[0], 1'h1, "measure bit set");
        step(30);
        check(counterValue[0], 8'hF0, "count before time base");
        i_pin_side_model.openWindow(); step(120);
        i_pin_side_model.closeWindow(); step(10);
        check(freqMeasureBit[0], 1'h0, "measure bit after window");
        held = counterValue[0];
        check(held >= 8'hF2 && held <= 8'hF6, 1'h1, "lower half after reload");
        check(counterValue[1], 8'hFF, "upper half reloaded");
        check(portBPin1, 1'h1, "upper overflow pin");
        step(60);
        check(counterValue[0], held, "count after window");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for ten cycles, then each scenario in turn.
    initial
    begin
        nFail = 0; cmpCount = 0; srst = 1'h1; runBit = 4'h0; captureEnable = 2'h0;
        clockSelect = '0; freqWrite = 2'h0; freqWriteData = 2'h0; writeData = 8'h00;
        counterWrite = 4'h0; dataWrite = 4'h0; statusRead = 2'h0; enableRegTwo = 4'h0;
        masterIrqEnable = 1'h0; requestClear = 4'h0;
        step(10); srst = 1'h0; step(1);
        check(overflowFlag, 4'h0, "reset flags");
        writeRegs();
        reloadAndIrq();
        stopCount();
        captureRun();
        freqMeasure();
        stopTest();
    end
endmodule
